// ### rtl/fbsr_shift_register.sv
// Behaviour
// - load_select high at a falling fall_clock edge loads all four parallel_in bits.
// - load_select low at a falling edge shifts stages one place toward stage three.
// - during a shift, serial_in enters stage zero at that same falling edge.
// - loads and shifts happen only on falling fall_clock edges, never rising ones.
// - mode, parallel and serial inputs matter only at the active falling edge.
// - clear_n low clears all stages and overrides the clock and the mode, parallel and serial inputs.
// - out_enable_n low drives the register contents onto parallel_out.
// - out_enable_n high releases the bus by clearing parallel_out_en; parallel_out still carries the stages.
// - output enable affects only the buffers; load, shift and clear carry on.
// - chain_out always shows stage three, even while parallel_out is released.
package fbsr_pkg;
    localparam int STAGES = 4;
    localparam logic [3:0] STAGE_RESET = 4'h0;
    localparam int LAST_STAGE = 3;
    localparam int FIFO_DEPTH = 16;
    // idle level of the pin history; low means no edge is seen straight after reset
    localparam logic FALL_CLOCK_IDLE = 1'h0;

    typedef enum logic [0:0]
    {
        FBSR_SHIFT = 1'b0,
        FBSR_LOAD = 1'b1
    } fbsr_mode_t;

    typedef struct packed
    {
        logic load_select;
        logic serial_in;
        logic [3:0] parallel_in;
    } fbsr_ctrl_t;

    // one record per register update, offered to the snapshot fifo and dropped when it is full
    typedef struct packed
    {
        fbsr_mode_t mode;
        logic [3:0] stages;
    } fbsr_snap_t;

    localparam int SNAP_WIDTH = $bits(fbsr_snap_t);
endpackage : fbsr_pkg

`timescale 1ns/10ps
`default_nettype none

module fbsr_shift_register #(
    parameter int FIFO_DEPTH = fbsr_pkg::FIFO_DEPTH
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic fall_clock,
    input wire logic clear_n,
    input wire logic load_select,
    input wire logic serial_in,
    input wire logic [3:0] parallel_in,
    input wire logic out_enable_n,
    output logic [3:0] parallel_out,
    output logic parallel_out_en,
    output logic chain_out,
    output logic snap_in_ready,
    output logic snap_valid,
    input wire logic snap_ready,
    output fbsr_pkg::fbsr_snap_t snap_data
);

    fbsr_pkg::fbsr_ctrl_t ctrl;
    logic fall_clock_q;
    logic next_fall_clock_q;
    logic [3:0] stages;
    logic [3:0] next_stages;
    logic next_chain_out;
    logic next_parallel_out_en;
    logic fall_edge;
    logic update;
    logic snap_push;
    logic [fbsr_pkg::SNAP_WIDTH-1:0] snap_raw;
    fbsr_pkg::fbsr_snap_t snap_word;

    function automatic logic [3:0] shift_step(input logic [3:0] cur, input logic din);
        shift_step = {cur[2:0], din};
    endfunction : shift_step

    assign ctrl = '{load_select: load_select, serial_in: serial_in, parallel_in: parallel_in};

    // a falling edge is the pin seen high last cycle and low now
    assign fall_edge = fall_clock_q & ~fall_clock;
    assign update = fall_edge & clear_n;

    always_comb
    begin
        next_fall_clock_q = fall_clock;
        next_stages = stages;
        if (!clear_n)
        begin
            next_stages = fbsr_pkg::STAGE_RESET;
        end
        else if (fall_edge)
        begin
            // inputs are looked at only here, so changes between edges do nothing
            if (fbsr_pkg::fbsr_mode_t'(ctrl.load_select) == fbsr_pkg::FBSR_LOAD)
            begin
                next_stages = ctrl.parallel_in;
            end
            else
            begin
                next_stages = shift_step(stages, ctrl.serial_in);
            end
        end
        // otherwise the stages hold, zero after a clear until an edge comes
        next_chain_out = next_stages[fbsr_pkg::LAST_STAGE];
        next_parallel_out_en = ~out_enable_n;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            fall_clock_q <= fbsr_pkg::FALL_CLOCK_IDLE;
            stages <= fbsr_pkg::STAGE_RESET;
            chain_out <= 1'h0;
            parallel_out_en <= 1'h0;
        end
        else
        begin
            fall_clock_q <= next_fall_clock_q;
            stages <= next_stages;
            chain_out <= next_chain_out;
            parallel_out_en <= next_parallel_out_en;
        end
    end

    // the value stays on parallel_out while released; the enable alone decides the bus
    assign parallel_out = stages;

    // each update is offered to the snapshot stream; a full fifo drops it, never the update
    assign snap_word = '{mode: fbsr_pkg::fbsr_mode_t'(ctrl.load_select), stages: next_stages};
    assign snap_push = update;

    fbsr_fifo #(
        .WIDTH(fbsr_pkg::SNAP_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_snap_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(snap_push),
        .in_ready(snap_in_ready),
        .in_data(snap_word),
        .out_valid(snap_valid),
        .out_ready(snap_ready),
        .out_data(snap_raw)
    );

    assign snap_data = fbsr_pkg::fbsr_snap_t'(snap_raw);

endmodule : fbsr_shift_register

`default_nettype wire

// ### rtl/fbsr_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module fbsr_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 16
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [PW-1:0] next_wr_ptr;
    logic [PW-1:0] next_rd_ptr;
    logic [CW-1:0] next_count;
    logic next_out_valid;
    logic next_in_ready;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == LAST_PTR) ? '0 : p + PW'(1);
    endfunction : ptr_inc

    assign push = in_valid & in_ready;
    // the output register refills when empty or when its word is taken
    assign pop = (count != '0) & (~out_valid | out_ready);

    always_comb
    begin
        next_wr_ptr = push ? ptr_inc(wr_ptr) : wr_ptr;
        next_rd_ptr = pop ? ptr_inc(rd_ptr) : rd_ptr;
        next_count = count + CW'(push) - CW'(pop);
        next_out_valid = pop | (out_valid & ~out_ready);
        next_in_ready = next_count != FULL_COUNT;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid <= 1'h0;
            in_ready <= 1'h1;
            out_data <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            out_valid <= next_out_valid;
            in_ready <= next_in_ready;
            if (pop)
            begin
                out_data <= mem[rd_ptr];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule : fbsr_fifo

`default_nettype wire

// ### bench/fbsr_properties.sv
`timescale 1ns/10ps
`default_nettype none
module fbsr_props(input wire logic clk_sys, rst, fall_clock, clear_n, load_select, serial_in,
    input wire logic [3:0] parallel_in, parallel_out, input wire logic out_enable_n,
    parallel_out_en, chain_out, snap_in_ready, snap_valid, snap_ready,
    input wire fbsr_pkg::fbsr_snap_t snap_data);
    logic fc_q;
    // edge history restarts low, as in the design, so no edge counts at release
    wire tk = fc_q && !fall_clock && clear_n;
    always_ff @(posedge clk_sys) fc_q <= rst ? 1'h0 : fall_clock;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_load_word:
        assert property (tk && load_select |=> parallel_out == $past(parallel_in))
        else $error("bad load");
    a_shift_step:
        assert property (tk && !load_select |=>
            parallel_out == {$past(parallel_out[2:0]), $past(serial_in)}) else $error("bad shift");
    a_hold_idle:
        assert property (!tk && clear_n |=> $stable(parallel_out)) else $error("moved");
    a_clear_zero:
        assert property (!clear_n |=> parallel_out == 4'h0 && !chain_out) else $error("no clear");
    a_drive_on:
        assert property (!out_enable_n |=> parallel_out_en) else $error("not driven");
    a_drive_off:
        assert property (out_enable_n |=> !parallel_out_en) else $error("not released");
    a_chain_last:
        assert property (chain_out == parallel_out[3]) else $error("bad chain");
    a_snap_stands:
        assert property (snap_valid && !snap_ready |=> snap_valid && $stable(snap_data))
        else $error("snap lost");
    c_load: cover property (tk && load_select);
    c_shift: cover property (tk && !load_select);
    c_full: cover property (snap_valid && !snap_in_ready);
endmodule : fbsr_props
`default_nettype wire

// ### bench/fbsr_sink.sv
`timescale 1ns/10ps
`default_nettype none
module fbsr_sink(input wire logic clk_sys, rst, stall, snap_valid,
    input wire fbsr_pkg::fbsr_snap_t snap_data, output logic snap_ready, output int count,
    output fbsr_pkg::fbsr_snap_t last);
    assign snap_ready = !stall;
    always_ff @(posedge clk_sys)
        if (rst)
            count <= 0;
        else if (snap_valid && snap_ready)
        begin
            count <= count + 1;
            last <= snap_data;
        end
endmodule : fbsr_sink
`default_nettype wire

// ### bench/fbsr_shift_register_test.sv
`timescale 1ns/10ps
`default_nettype none
module fbsr_shift_register_test;
    logic clk_sys = 0, rst = 1, fall_clock = 0, clear_n = 1, load_select = 0, serial_in = 0;
    logic out_enable_n = 1, stall = 0, parallel_out_en, chain_out, snap_in_ready, snap_valid;
    logic snap_ready;
    logic [3:0] parallel_in = 4'h0, parallel_out, exp_reg = 4'h0;
    logic [3:0] pat [4] = '{4'h0, 4'hf, 4'ha, 4'h5};
    fbsr_pkg::fbsr_snap_t snap_data, last;
    int count, n_fail = 0, cmp_count = 0;
    fbsr_shift_register fbsr_shift_register_i (.*);
    fbsr_sink fbsr_sink_i (.*);
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic op(input logic ls, input logic si, input logic [3:0] pi);
        fall_clock = 1;
        cyc(1);
        fall_clock = 0;
        load_select = ls;
        serial_in = si;
        parallel_in = pi;
        if (clear_n)
            exp_reg = ls ? pi : {exp_reg[2:0], si};
        cyc(1);
        chk({chain_out, parallel_out}, {exp_reg[3], exp_reg});
        chk({4'h0, parallel_out_en}, {4'h0, ~out_enable_n});
    endtask : op
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task automatic t_load;
        foreach (pat[i])
        begin
            out_enable_n = i[0];
            op(1, 0, pat[i]);
        end
    endtask : t_load
    task automatic t_shift;
        for (int i = 0; i < 4; i++)
            op(0, i != 1, 4'hc);
        // the bench acts as the next device: stage three fed back as serial input
        op(0, chain_out, 4'h3);
    endtask : t_shift
    task automatic t_ignore;
        op(1, 0, 4'h3);
        fall_clock = 1;
        parallel_in = 4'hc;
        cyc(2);
        load_select = 0;
        parallel_in = 4'h6;
        cyc(2);
        chk({1'h0, parallel_out}, 5'h03);
    endtask : t_ignore
    task automatic t_clear;
        clear_n = 0;
        exp_reg = 4'h0;
        op(1, 0, 4'h9);
        clear_n = 1;
        cyc(3);
        chk({1'h0, parallel_out}, 5'h00);
        op(0, 1, 4'h9);
    endtask : t_clear
    task automatic t_fifo;
        int base;
        int k;
        cyc(4);
        base = count;
        stall = 1;
        for (int i = 0; i < 20; i++)
            op(1, 0, ~i[3:0]);
        cyc(3);
        chk({4'h0, snap_in_ready}, 5'h00);
        stall = 0;
        for (k = 0; k < 40 && count != base + 17; k++)
            cyc(1);
        if (k == 40)
        begin
            n_fail++;
            end_of_test;
        end
        cyc(4);
        chk(5'(count - base), 5'h11);
        chk(last, {fbsr_pkg::FBSR_LOAD, 4'hf});
    endtask : t_fifo
    initial
    begin
        cyc(6);
        rst = 0;
        t_load;
        t_shift;
        t_ignore;
        t_clear;
        t_fifo;
        end_of_test;
    end
endmodule : fbsr_shift_register_test
bind fbsr_shift_register fbsr_props fbsr_props_i (.*);
`default_nettype wire
